// ===== design/ucg_consts.vh
// Constants for the serial clock generator and frame formatter
`ifndef UCG_CONSTS_VH
`define UCG_CONSTS_VH
// Register offsets
`define UCG_ADDR_DIV_LO 4'h0
`define UCG_ADDR_DIV_HI 4'h1
`define UCG_ADDR_CTRL 4'h2
`define UCG_ADDR_FMT 4'h3
`define UCG_ADDR_TXDATA 4'h4
`define UCG_ADDR_RXDATA 4'h5
`define UCG_ADDR_STAT 4'h6
// Control bit positions
`define UCG_CTRL_TX_ENABLE 0
`define UCG_CTRL_RXEN 1
`define UCG_CTRL_SYNC 2
`define UCG_CTRL_CKDIR 3
`define UCG_CTRL_DBL 4
`define UCG_CTRL_CPOL 5
// Format bit positions
`define UCG_FMT_CSZ_LSB 0
`define UCG_FMT_PM_LSB 3
`define UCG_FMT_SBS 5
// Status bit positions
`define UCG_STAT_TXC 0
`define UCG_STAT_RXC 1
`define UCG_STAT_FE 2
`define UCG_STAT_TXBUSY 3
`define UCG_STAT_PE 4
// Reset values
`define UCG_CTRL_RST 6'h00
`define UCG_FMT_RST 6'h06
`define UCG_DIV_RST 12'h000
// Oversampling counts
`define UCG_OVS_NORMAL 5'h10
`define UCG_OVS_DOUBLE 5'h08
`define UCG_OVS_SYNC 5'h02
`endif

// ===== design/ucg_baud_gen.v
// Baud generator down-counter emitting a one-cycle tick
`timescale 1ns/1ps
module ucg_baud_gen (
  input wire clk_sys_in,
  input wire reset_n_in,
  input wire [11:0] divisor_in,
  input wire reload_in,
  output wire tick_out
);
  reg [11:0] count_q;
  // Count down, reload on zero or on low-byte write
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_q <= 12'h000;
    end else if (reload_in || count_q == 12'h000) begin
      count_q <= divisor_in;
    end else begin
      count_q <= count_q - 12'h001;
    end
  end
  // Tick is an enable pulse, not a clock
  assign tick_out = (count_q == 12'h000);
endmodule

// ===== design/ucg_usart.v
// Serial clock generator, frame formatter, transmitter and receiver
`timescale 1ns/1ps
`include "ucg_consts.vh"
module ucg_usart (
  input wire clk_sys_in,
  input wire reset_n_in,
  input wire [3:0] addr_in,
  input wire [8:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [8:0] rdata_out,
  input wire serial_in_pin_in,
  input wire port_out_level_in,
  output reg serial_out_pin_out,
  input wire xck_in,
  output wire xck_out,
  output wire xck_oe_out
);
  // ************************************************************
  // Registers
  // ************************************************************
  reg [7:0] div_lo_q;
  reg [3:0] div_hi_q;
  reg [5:0] ctrl_q;
  reg [5:0] fmt_q;
  reg txc_q, rxc_q, fe_q, pe_q;
  reg [8:0] rx_buf_q;
  reg tx_pend_q;
  reg [8:0] tx_buf_q;
  wire tick;
  wire tx_start;
  wire tx_done;
  wire rx_done;
  wire rx_fe;
  wire rx_pe;
  wire [8:0] rx_word;
  wire tx_busy;
  wire tx_en = ctrl_q[`UCG_CTRL_TX_ENABLE];
  wire rx_en = ctrl_q[`UCG_CTRL_RXEN];
  wire sync_mode = ctrl_q[`UCG_CTRL_SYNC];
  wire master = ctrl_q[`UCG_CTRL_CKDIR];
  wire dbl = ctrl_q[`UCG_CTRL_DBL] & ~sync_mode;
  wire cpol = ctrl_q[`UCG_CTRL_CPOL];
  wire [2:0] csz = fmt_q[`UCG_FMT_CSZ_LSB +: 3];
  wire [1:0] pmode = fmt_q[`UCG_FMT_PM_LSB +: 2];
  wire two_stop = fmt_q[`UCG_FMT_SBS];
  wire [11:0] divisor = {div_hi_q, div_lo_q};
  wire wr_lo = wr_in && addr_in == `UCG_ADDR_DIV_LO;

  // Number of data bits from the size field
  function [3:0] data_bits;
    input [2:0] sz;
    begin
      case (sz)
        3'h0: data_bits = 4'h5;
        3'h1: data_bits = 4'h6;
        3'h2: data_bits = 4'h7;
        3'h7: data_bits = 4'h9;
        default: data_bits = 4'h8;
      endcase
    end
  endfunction

  // Parity over the active data bits
  function par_of;
    input [8:0] d;
    input [3:0] n;
    input odd;
    integer i;
    reg p;
    begin
      p = odd;
      for (i = 0; i < 9; i = i + 1) begin
        if (i < n) begin
          p = p ^ d[i];
        end
      end
      par_of = p;
    end
  endfunction

  wire [3:0] nbits = data_bits(csz);

  // Register writes and sticky flags, set wins over clear
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_lo_q <= 8'h00;
      div_hi_q <= 4'h0;
      ctrl_q <= `UCG_CTRL_RST;
      fmt_q <= `UCG_FMT_RST;
      txc_q <= 1'b0;
      rxc_q <= 1'b0;
      fe_q <= 1'b0;
      pe_q <= 1'b0;
      rx_buf_q <= 9'h000;
      tx_pend_q <= 1'b0;
      tx_buf_q <= 9'h000;
    end else begin
      if (wr_lo) begin
        div_lo_q <= wdata_in[7:0];
      end
      if (wr_in && addr_in == `UCG_ADDR_DIV_HI) begin
        div_hi_q <= wdata_in[3:0];
      end
      if (wr_in && addr_in == `UCG_ADDR_CTRL) begin
        ctrl_q <= wdata_in[5:0];
      end
      if (wr_in && addr_in == `UCG_ADDR_FMT) begin
        fmt_q <= wdata_in[5:0];
      end
      if (wr_in && addr_in == `UCG_ADDR_TXDATA && tx_en) begin
        tx_buf_q <= wdata_in;
        tx_pend_q <= 1'b1;
      end else if (tx_start) begin
        tx_pend_q <= 1'b0;
      end
      // Write one to clear transmit complete
      if (tx_done && !tx_pend_q) begin
        txc_q <= 1'b1;
      end else if (wr_in && addr_in == `UCG_ADDR_STAT && wdata_in[`UCG_STAT_TXC]) begin
        txc_q <= 1'b0;
      end
      // Reading the data clears receive complete
      if (rx_done) begin
        rxc_q <= 1'b1;
        rx_buf_q <= rx_word;
        fe_q <= rx_fe;
        pe_q <= rx_pe;
      end else if (rd_in && addr_in == `UCG_ADDR_RXDATA) begin
        rxc_q <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 9'h000;
    end else if (rd_in) begin
      case (addr_in)
        `UCG_ADDR_DIV_LO: rdata_out <= {1'b0, div_lo_q};
        `UCG_ADDR_DIV_HI: rdata_out <= {5'h00, div_hi_q};
        `UCG_ADDR_CTRL: rdata_out <= {3'h0, ctrl_q};
        `UCG_ADDR_FMT: rdata_out <= {3'h0, fmt_q};
        `UCG_ADDR_RXDATA: rdata_out <= rx_buf_q;
        `UCG_ADDR_STAT: rdata_out <= {4'h0, pe_q, tx_busy, fe_q, rxc_q, txc_q};
        default: rdata_out <= 9'h000;
      endcase
    end else begin
      rdata_out <= 9'h000;
    end
  end

  // ************************************************************
  // Clock generation
  // ************************************************************
  ucg_baud_gen u_baud (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .divisor_in(divisor),
    .reload_in(wr_lo),
    .tick_out(tick)
  );

  // Samples per bit from mode
  wire [4:0] ovs = sync_mode ? `UCG_OVS_SYNC : (dbl ? `UCG_OVS_DOUBLE : `UCG_OVS_NORMAL);

  // External clock synchroniser and edge detector
  reg xck_s1_q, xck_s2_q, xck_s3_q;
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      xck_s1_q <= 1'b0;
      xck_s2_q <= 1'b0;
      xck_s3_q <= 1'b0;
    end else begin
      xck_s1_q <= xck_in;
      xck_s2_q <= xck_s1_q;
      xck_s3_q <= xck_s2_q;
    end
  end
  wire ext_rise = xck_s2_q & ~xck_s3_q;
  wire ext_fall = ~xck_s2_q & xck_s3_q;

  // Master clock: toggles every tick, one period per two ticks
  reg mck_q;
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mck_q <= 1'b0;
    end else if (!(sync_mode && master)) begin
      mck_q <= 1'b0;
    end else if (tick) begin
      mck_q <= ~mck_q;
    end
  end
  // Edges named by the pin level, so polarity cannot swap them
  wire m_rise = tick & ~xck_out & sync_mode & master;
  wire m_fall = tick & xck_out & sync_mode & master;
  wire s_rise = master ? m_rise : ext_rise;
  wire s_fall = master ? m_fall : ext_fall;
  // Change edge and sample edge per polarity
  wire sync_change = cpol ? s_fall : s_rise;
  wire sync_sample = cpol ? s_rise : s_fall;
  // Idle pin level follows polarity so first edge is a change edge
  assign xck_out = mck_q ^ cpol;
  assign xck_oe_out = sync_mode & master & tx_en;

  // Asynchronous transmit bit enable: tick divided by samples per bit
  reg [4:0] tx_div_q;
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_div_q <= 5'h00;
    end else if (tick) begin
      tx_div_q <= (tx_div_q >= ovs - 5'h01) ? 5'h00 : tx_div_q + 5'h01;
    end
  end
  wire async_tx_en = tick && tx_div_q == ovs - 5'h01;
  wire tx_bit_en = sync_mode ? sync_change : async_tx_en;

  // ************************************************************
  // Transmitter
  // ************************************************************
  reg [11:0] tx_sh_q;
  reg [3:0] tx_cnt_q;
  reg tx_act_q;
  wire tx_par = par_of(tx_buf_q, nbits, pmode[0]);
  wire [3:0] tx_len = 4'h1 + nbits + {3'h0, pmode[1]} + {3'h0, two_stop};
  // Frame: start, data LSB first, optional parity, stops
  reg [11:0] tx_frame;
  integer j;
  always @* begin
    tx_frame = 12'hFFF;
    tx_frame[0] = 1'b0;
    // Only active data positions are replaced, the rest stay stop level
    for (j = 0; j < 9; j = j + 1) begin
      if (j < nbits) begin
        tx_frame[j + 1] = tx_buf_q[j];
      end
    end
    if (pmode[1]) begin
      tx_frame[nbits + 4'h1] = tx_par;
    end
  end
  assign tx_start = tx_bit_en && !tx_act_q && tx_pend_q;
  assign tx_done = tx_bit_en && tx_act_q && tx_cnt_q == tx_len;
  assign tx_busy = tx_act_q | tx_pend_q;
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_sh_q <= 12'hFFF;
      tx_cnt_q <= 4'h0;
      tx_act_q <= 1'b0;
    end else if (tx_bit_en) begin
      if (tx_act_q && tx_cnt_q != tx_len) begin
        tx_sh_q <= {1'b1, tx_sh_q[11:1]};
        tx_cnt_q <= tx_cnt_q + 4'h1;
      end else if (tx_pend_q) begin
        tx_sh_q <= tx_frame; // Back to back frames
        tx_cnt_q <= 4'h1;
        tx_act_q <= 1'b1;
      end else begin
        tx_sh_q <= 12'hFFF;
        tx_act_q <= 1'b0;
      end
    end
  end
  // Pin owned by transmitter while enabled or still draining
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      serial_out_pin_out <= 1'b1;
    end else if (tx_en || tx_busy) begin
      serial_out_pin_out <= tx_act_q ? tx_sh_q[0] : 1'b1;
    end else begin
      serial_out_pin_out <= port_out_level_in;
    end
  end

  // ************************************************************
  // Receiver
  // ************************************************************
  reg [4:0] rx_ph_q;
  reg [3:0] rx_cnt_q;
  reg rx_act_q;
  reg [8:0] rx_sh_q;
  reg rx_par_q;
  reg rx_done_q, rx_fe_q;
  wire rx_mid = sync_mode ? sync_sample : (tick && rx_ph_q == (ovs >> 1));
  wire [3:0] rx_last = nbits + {3'h0, pmode[1]} + 4'h1; // First stop bit index
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_ph_q <= 5'h00;
      rx_cnt_q <= 4'h0;
      rx_act_q <= 1'b0;
      rx_sh_q <= 9'h000;
      rx_par_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_fe_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (!rx_en) begin
        rx_act_q <= 1'b0;
      end else if (!rx_act_q) begin
        // Wait for low start level
        if ((sync_mode ? sync_sample : tick) && !serial_in_pin_in) begin
          rx_act_q <= 1'b1;
          rx_ph_q <= sync_mode ? 5'h00 : 5'h01;
          rx_cnt_q <= sync_mode ? 4'h1 : 4'h0;
          rx_sh_q <= 9'h000;
        end
      end else begin
        if (tick) begin
          rx_ph_q <= (rx_ph_q >= ovs - 5'h01) ? 5'h00 : rx_ph_q + 5'h01;
        end
        if (rx_mid) begin
          if (rx_cnt_q == 4'h0 && serial_in_pin_in) begin
            rx_act_q <= 1'b0; // False start
          end else if (rx_cnt_q >= 4'h1 && rx_cnt_q <= nbits) begin
            rx_sh_q[rx_cnt_q - 4'h1] <= serial_in_pin_in;
          end else if (rx_cnt_q == rx_last - 4'h1 && pmode[1]) begin
            rx_par_q <= serial_in_pin_in;
          end
          if (rx_cnt_q == rx_last) begin
            rx_act_q <= 1'b0; // Second stop bit ignored
            rx_done_q <= 1'b1;
            rx_fe_q <= ~serial_in_pin_in;
          end
          rx_cnt_q <= rx_cnt_q + 4'h1;
        end
      end
    end
  end
  assign rx_done = rx_done_q;
  assign rx_fe = rx_fe_q;
  assign rx_word = rx_sh_q;
  assign rx_pe = pmode[1] & (rx_par_q != par_of(rx_sh_q, nbits, pmode[0]));
endmodule

// ===== sim/ucg_usart_asserts.sv
// Port-level checker for the serial clock generator and frame formatter
`timescale 1ns/1ps
`include "ucg_consts.vh"
module ucg_usart_asserts (
  input wire clk_sys_in,
  input wire reset_n_in,
  input wire [3:0] addr_in,
  input wire [8:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [8:0] rdata_out,
  input wire serial_in_pin_in,
  input wire port_out_level_in,
  input wire serial_out_pin_out,
  input wire xck_in,
  input wire xck_out,
  input wire xck_oe_out
);
  reg [5:0] ctl_q;
  reg [11:0] div_q;
  reg [1:0] age_q;
  reg [23:0] run_q;
  reg so_q;
  reg ever_q;
  wire settled = (age_q == 2'h3);
  wire [23:0] bit_len = ({12'h000, div_q} + 24'h1) * (ctl_q[4] ? 24'h8 : 24'h10);
  // Shadow of control and divisor, plus length of the current line level
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_q <= 6'h00;
      div_q <= 12'h000;
      age_q <= 2'h0;
      run_q <= 24'h0;
      so_q <= 1'b1;
      ever_q <= 1'b0;
    end else begin
      if (wr_in && addr_in == `UCG_ADDR_CTRL) begin
        ctl_q <= wdata_in[5:0];
        age_q <= 2'h0;
      end else if (!settled) begin
        age_q <= age_q + 2'h1;
      end
      if (wr_in && addr_in == `UCG_ADDR_DIV_LO) div_q[7:0] <= wdata_in[7:0];
      if (wr_in && addr_in == `UCG_ADDR_DIV_HI) div_q[11:8] <= wdata_in[3:0];
      run_q <= (serial_out_pin_out != so_q) ? 24'h1 : run_q + 24'h1;
      so_q <= serial_out_pin_out;
      ever_q <= ever_q | ctl_q[0];
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // Rise after a low run inside an asynchronous frame
  sequence s_low_end;
    settled && ctl_q[0] && !ctl_q[2] && !so_q ##0 serial_out_pin_out;
  endsequence
  a_oe_master: assert property (settled |-> xck_oe_out == (ctl_q[0] & ctl_q[2] & ctl_q[3]))
    else $error("clock pin enable wrong for mode");
  a_port_level: assert property (settled && !ever_q && $stable(port_out_level_in)
    |=> serial_out_pin_out == $past(port_out_level_in))
    else $error("serial out not following port level");
  a_low_run: assert property (s_low_end |-> run_q != 24'h0 && (run_q % bit_len) == 24'h0)
    else $error("low run not whole bits");
  a_sync_edge: assert property (settled && ctl_q[0] && ctl_q[2] && ctl_q[3] && $changed(serial_out_pin_out)
    |-> xck_out != ctl_q[5])
    else $error("data changed on wrong clock edge");
  a_rd_quiet: assert property (!rd_in |=> rdata_out == 9'h000)
    else $error("read data outside answer cycle");
  a_div_hi: assert property (rd_in && addr_in == `UCG_ADDR_DIV_HI |=> rdata_out == {5'h00, div_q[11:8]})
    else $error("divisor high readback wrong");
  a_div_lo: assert property (rd_in && addr_in == `UCG_ADDR_DIV_LO |=> rdata_out == {1'b0, div_q[7:0]})
    else $error("divisor low readback wrong");
  a_unmapped_rd: assert property (rd_in && addr_in > 4'h6 |=> rdata_out == 9'h000)
    else $error("unmapped read not zero");
endmodule
bind ucg_usart ucg_usart_asserts u_ucg_usart_asserts (.clk_sys_in, .reset_n_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .serial_in_pin_in, .port_out_level_in, .serial_out_pin_out, .xck_in, .xck_out, .xck_oe_out);

// ===== sim/ucg_peer.sv
// Remote serial transceiver model on the data lines
`timescale 1ns/1ps
module ucg_peer (
  input wire clk_sys_in,
  input wire line_in,
  output reg line_out
);
  int bitc = 32;
  // Line rests high between frames
  initial line_out = 1'b1;
  // Send n line bits, first bit first
  task automatic send(input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= b[i];
      repeat (bitc) @(posedge clk_sys_in);
    end
    line_out <= 1'b1;
  endtask
  // Wait for a start edge, then sample each bit at its middle
  task automatic recv(output logic [15:0] b, input int n, output bit ok);
    ok = 1'b0;
    b = 16'hFFFF;
    for (int k = 0; k < 4000 && !ok; k++) begin
      @(posedge clk_sys_in);
      ok = !line_in;
    end
    if (ok) begin
      repeat (bitc / 2) @(posedge clk_sys_in);
      for (int i = 0; i < n; i++) begin
        b[i] = line_in;
        repeat (bitc) @(posedge clk_sys_in);
      end
    end
  endtask
endmodule

// ===== sim/ucg_usart_tb_top.sv
// Self-checking testbench for the serial clock generator and frame formatter
`timescale 1ns/1ps
`include "ucg_consts.vh"
module ucg_usart_tb_top;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic port_out_level_in = 1'b1;
  logic xck_drv = 1'b0;
  logic [2:0] sl_exp = 3'b010;
  logic [3:0] addr_in = 4'h0;
  logic [8:0] wdata_in = 9'h000;
  wire [8:0] rdata_out;
  wire rx_line, serial_out_pin_out, xck_out, xck_oe_out;
  int num_errors = 0;
  int num_checks = 0;
  logic [15:0] fr, got;
  logic [8:0] v;
  int n;
  bit ok;
  logic [5:0] tc [3] = '{6'h01, 6'h11, 6'h01};
  logic [5:0] tf [3] = '{6'h33, 6'h18, 6'h07};
  logic [8:0] td [3] = '{9'h0A5, 9'h01B, 9'h1A5};
  ucg_usart u_ucg_usart (.clk_sys_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .serial_in_pin_in(rx_line), .port_out_level_in, .serial_out_pin_out, .xck_in(xck_drv), .xck_out, .xck_oe_out);
  ucg_peer u_ucg_peer (.clk_sys_in, .line_in(serial_out_pin_out), .line_out(rx_line));
  // 100 ns system clock
  initial forever #50 clk_sys_in = ~clk_sys_in;
  // ****
  // Bus tasks and checks
  // ****
  task automatic wr(input logic [3:0] a, input logic [8:0] d);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [3:0] a, output logic [8:0] d);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(posedge clk_sys_in);
    d = rdata_out;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Expected line bits: start, data LSB first, optional parity, stops
  function automatic logic [15:0] frame(input logic [8:0] d, input logic [5:0] f, output int len);
    int nb;
    logic p;
    frame = 16'hFFFF;
    frame[0] = 1'b0;
    nb = (f[2:0] == 3'h7) ? 9 : f[2:0] + 5;
    p = f[3];
    for (int i = 0; i < nb; i++) begin
      frame[i + 1] = d[i];
      p = p ^ d[i];
    end
    len = nb + 1;
    if (f[4]) begin
      frame[len] = p;
      len++;
    end
    len = len + 1 + f[5];
  endfunction
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (10) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rd(`UCG_ADDR_FMT, v); chk(v, 9'h006);
    rd(`UCG_ADDR_CTRL, v); chk(v, 9'h000);
    wr(4'h9, 9'h0FF);
    rd(4'h9, v); chk(v, 9'h000);
    wr(`UCG_ADDR_DIV_HI, 9'h1FF);
    rd(`UCG_ADDR_DIV_HI, v); chk(v, 9'h00F);
    wr(`UCG_ADDR_DIV_HI, 9'h000);
    wr(`UCG_ADDR_DIV_LO, 9'h001);
    rd(`UCG_ADDR_DIV_LO, v); chk(v, 9'h001);
    port_out_level_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk(serial_out_pin_out, 1'b0);
    // Transmit frames in normal and double speed, several formats
    for (int c = 0; c < 3; c++) begin
      u_ucg_peer.bitc = tc[c][4] ? 16 : 32;
      rd(`UCG_ADDR_STAT, v); chk(v[`UCG_STAT_TXBUSY], 1'b0);
      wr(`UCG_ADDR_FMT, {3'h0, tf[c]});
      wr(`UCG_ADDR_CTRL, {3'h0, tc[c]});
      repeat (2) @(posedge clk_sys_in);
      chk(serial_out_pin_out, 1'b1);
      wr(`UCG_ADDR_STAT, 9'h001);
      wr(`UCG_ADDR_TXDATA, td[c]);
      fr = frame(td[c], tf[c], n);
      u_ucg_peer.recv(got, n, ok);
      chk(ok, 1'b1);
      if (!ok) finish_test();
      chk(got, fr);
      repeat (2 * u_ucg_peer.bitc) @(posedge clk_sys_in);
      rd(`UCG_ADDR_STAT, v); chk(v[`UCG_STAT_TXC], 1'b1);
    end
    // Receive a frame with a bad first stop bit, then a good one
    u_ucg_peer.bitc = 32;
    wr(`UCG_ADDR_FMT, 9'h003);
    wr(`UCG_ADDR_CTRL, 9'h003);
    fr = frame(9'h03C, 6'h03, n);
    fr[9] = 1'b0;
    u_ucg_peer.send(fr, n);
    repeat (64) @(posedge clk_sys_in);
    rd(`UCG_ADDR_STAT, v); chk(v[`UCG_STAT_FE], 1'b1);
    rd(`UCG_ADDR_RXDATA, v);
    fr = frame(9'h05A, 6'h03, n);
    u_ucg_peer.send(fr, n);
    repeat (64) @(posedge clk_sys_in);
    rd(`UCG_ADDR_STAT, v); chk(v[`UCG_STAT_FE], 1'b0);
    rd(`UCG_ADDR_RXDATA, v); chk(v, 9'h05A);
    // Synchronous master with both clock polarities, then slave
    wr(`UCG_ADDR_DIV_LO, 9'h002);
    for (int cp = 0; cp < 2; cp++) begin
      wr(`UCG_ADDR_CTRL, cp ? 9'h02D : 9'h00D);
      repeat (3) @(posedge clk_sys_in);
      chk(xck_oe_out, 1'b1);
      wr(`UCG_ADDR_TXDATA, 9'h096);
      repeat (150) @(posedge clk_sys_in);
    end
    wr(`UCG_ADDR_CTRL, 9'h005);
    repeat (3) @(posedge clk_sys_in);
    chk(xck_oe_out, 1'b0);
    // Slave: external clock of eight system clocks, start then data on rising edges
    wr(`UCG_ADDR_TXDATA, 9'h001);
    for (int k = 0; k < 3; k++) begin
      xck_drv <= 1'b1;
      repeat (5) @(posedge clk_sys_in);
      chk(serial_out_pin_out, sl_exp[k]);
      xck_drv <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
    end
    finish_test();
  end
endmodule
